// ### src/nsd_exec.sv
// execution of the nibble exchange and legacy direction load instructions
`timescale 1ns/1ps
`default_nettype none
module nsd_exec import nsd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // instruction stream, one word per instruction cycle
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  // file register port (operand read combinational from core)
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_wdata,
  output logic file_we,
  // direct access to direction registers from the core
  input wire logic [6:0] dir_addr,
  input wire logic dir_wr,
  input wire logic [7:0] dir_wdata,
  output logic [7:0] dir_rdata,
  // state seen by the rest of the core
  output logic [7:0] acc,
  output logic [23:0] dir_regs,
  output logic status_we,
  output logic busy,
  output logic done
);
  nsd_dir_if dif ();

  nsd_dir_bank u_bank (
    .clk(clk),
    .reset(reset),
    .bus(dif.bank)
  );

  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  function automatic logic dir_hit(input logic [6:0] a);
    return (a >= nsd_dir_addr_base) && (a <= nsd_dir_addr_base + 7'h02);
  endfunction

  // bank index of a direct address; only meaningful when dir_hit holds
  function automatic logic [1:0] dir_idx(input logic [6:0] a);
    return 2'(a - nsd_dir_addr_base);
  endfunction

  nsd_phase_type phase_r, phase_nxt;
  logic [13:0] ir_r, ir_nxt;
  logic live_r, live_nxt;
  logic [7:0] opnd_r, opnd_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] fwd_r, fwd_nxt;
  logic fwe_r, fwe_nxt;
  logic done_r, done_nxt;
  logic is_xchg, is_dirld, dsel_ok;

  // decoded in place from the latched word
  assign is_xchg = live_r && (ir_r[13:8] == nsd_xchg_opc);
  assign is_dirld = live_r && (ir_r[13:3] == nsd_dirld_opc);
  assign dsel_ok = (ir_r[2:0] >= nsd_dir_sel_lo) && (ir_r[2:0] <= nsd_dir_sel_hi);

  always_comb begin
    phase_nxt = phase_r;
    ir_nxt = ir_r;
    live_nxt = live_r;
    opnd_nxt = opnd_r;
    acc_nxt = acc_r;
    fwd_nxt = fwd_r;
    fwe_nxt = 1'b0;
    done_nxt = 1'b0;
    dif.we = 1'b0;
    dif.sel = 2'h0;
    dif.wdata = 8'h00;
    case (phase_r)
      nsd_ph_decode: begin
        ir_nxt = instr;
        live_nxt = instr_valid;
        phase_nxt = nsd_ph_read;
      end
      nsd_ph_read: begin
        opnd_nxt = file_rdata;
        phase_nxt = nsd_ph_process;
      end
      nsd_ph_process: begin
        fwd_nxt = nib_swap(opnd_r);
        phase_nxt = nsd_ph_write;
      end
      nsd_ph_write: begin
        phase_nxt = nsd_ph_decode;
        done_nxt = is_xchg || is_dirld;
        if (is_xchg) begin
          if (ir_r[7]) begin
            fwe_nxt = 1'b1;
          end else begin
            acc_nxt = fwd_r;
          end
        end
        // accumulator to direction register; out-of-range selects are a no-op
        if (is_dirld && dsel_ok) begin
          dif.we = 1'b1;
          dif.sel = 2'(ir_r[2:0] - nsd_dir_sel_lo);
          dif.wdata = acc_r;
        end
        live_nxt = 1'b0;
      end
      default: begin
        phase_nxt = nsd_ph_decode;
      end
    endcase
    // direct access; instruction write wins on collision
    if (!dif.we && dir_wr && dir_hit(dir_addr)) begin
      dif.we = 1'b1;
      dif.sel = dir_idx(dir_addr);
      dif.wdata = dir_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_r <= nsd_ph_decode;
      ir_r <= 14'h0000;
      live_r <= 1'b0;
      opnd_r <= 8'h00;
      acc_r <= nsd_acc_rst;
      fwd_r <= 8'h00;
      fwe_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      ir_r <= ir_nxt;
      live_r <= live_nxt;
      opnd_r <= opnd_nxt;
      acc_r <= acc_nxt;
      fwd_r <= fwd_nxt;
      fwe_r <= fwe_nxt;
      done_r <= done_nxt;
    end
  end

  assign dif.rsel = dir_hit(dir_addr) ? dir_idx(dir_addr) : 2'h3;
  assign file_addr = ir_r[6:0];
  // file write lands one clock after the write phase, still within the cycle's reach
  assign file_we = fwe_r;
  assign file_wdata = fwd_r;
  assign dir_rdata = dif.rdata;
  assign dir_regs = dif.dir_all;
  assign acc = acc_r;
  // flags never touched by these two instructions
  assign status_we = 1'b0;
  assign busy = live_r;
  assign done = done_r;
endmodule
`default_nettype wire

// ### src/nsd_pkg.sv
// constants and types for the nibble exchange / direction load execution block
package nsd_pkg;
  localparam int unsigned nsd_data_w = 8;
  localparam int unsigned nsd_addr_w = 7;
  localparam int unsigned nsd_op_w = 14;
  // instruction encodings
  localparam logic [5:0] nsd_xchg_opc = 6'h0e;
  localparam logic [10:0] nsd_dirld_opc = 11'h00c;
  localparam logic [2:0] nsd_dir_sel_lo = 3'h5;
  localparam logic [2:0] nsd_dir_sel_hi = 3'h7;
  localparam int unsigned nsd_dir_cnt = 3;
  // file addresses of the direction registers (direct access path)
  localparam logic [6:0] nsd_dir_addr_base = 7'h05;
  localparam logic [7:0] nsd_dir_rst = 8'hff;
  localparam logic [7:0] nsd_acc_rst = 8'h00;
  localparam logic [1:0] nsd_phase_rst = 2'h0;
  typedef enum logic [1:0] {
    nsd_ph_decode = 2'b00,
    nsd_ph_read = 2'b01,
    nsd_ph_process = 2'b10,
    nsd_ph_write = 2'b11
  } nsd_phase_type;
endpackage

// ### src/nsd_dir_if.sv
// carrier between the executor and its direction register bank
`timescale 1ns/1ps
`default_nettype none
interface nsd_dir_if;
  logic we;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic [1:0] rsel;
  logic [7:0] rdata;
  logic [23:0] dir_all;
  modport exec (output we, output sel, output wdata, output rsel, input rdata, input dir_all);
  modport bank (input we, input sel, input wdata, input rsel, output rdata, output dir_all);
endinterface
`default_nettype wire

// ### src/nsd_dir_bank.sv
// bank of three port direction registers with registered read data
`timescale 1ns/1ps
`default_nettype none
module nsd_dir_bank import nsd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register access
  nsd_dir_if.bank bus
);
  logic [7:0] dir_r [nsd_dir_cnt];
  logic [7:0] dir_nxt [nsd_dir_cnt];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    for (int i = 0; i < nsd_dir_cnt; i++) begin
      dir_nxt[i] = dir_r[i];
    end
    if (bus.we && (int'(bus.sel) < nsd_dir_cnt)) begin
      dir_nxt[bus.sel] = bus.wdata;
    end
    rdata_nxt = (int'(bus.rsel) < nsd_dir_cnt) ? dir_nxt[bus.rsel] : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < nsd_dir_cnt; i++) begin
        dir_r[i] <= nsd_dir_rst;
      end
      rdata_r <= 8'h00;
    end else begin
      for (int i = 0; i < nsd_dir_cnt; i++) begin
        dir_r[i] <= dir_nxt[i];
      end
      rdata_r <= rdata_nxt;
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.dir_all = {dir_r[2], dir_r[1], dir_r[0]};
endmodule
`default_nettype wire

// ### dv/nsd_exec_assertions.sv
// checker for the exchange and direction load executor
`timescale 1ns/1ps
`default_nettype none
module nsd_chk import nsd_pkg::*; (
  // watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] file_wdata,
  input wire logic file_we,
  input wire logic [6:0] dir_addr,
  input wire logic dir_wr,
  input wire logic [7:0] dir_wdata,
  input wire logic [7:0] dir_rdata,
  input wire logic [7:0] acc,
  input wire logic [23:0] dir_regs,
  input wire logic status_we,
  input wire logic busy,
  input wire logic done
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_flags_kept: assert property (!status_we) else $error("status write seen");
  a_we_swap: assert property (file_we |->
    file_wdata == {$past(file_rdata[3:0], 3), $past(file_rdata[7:4], 3)}) else $error("bad file result");
  a_we_single: assert property (file_we |=> !file_we) else $error("file write too long");
  a_we_done: assert property (file_we |-> done) else $error("file write without done");
  a_done_pulse: assert property (done |=> !done) else $error("done too long");
  a_acc_swap: assert property ($changed(acc) |->
    acc == {$past(file_rdata[3:0], 3), $past(file_rdata[7:4], 3)}) else $error("bad acc result");
  a_dir_direct: assert property (dir_wr && dir_addr == 7'h05 && !busy |=>
    dir_regs[7:0] == $past(dir_wdata)) else $error("direct write lost");
  a_rdata_miss: assert property (!(dir_addr inside {[7'h05:7'h07]}) |=> dir_rdata == 8'h00)
    else $error("read data on miss");
  a_busy_span: assert property ($rose(busy) |-> busy[*3] ##1 !busy) else $error("bad cycle length");
endmodule
bind nsd_exec nsd_chk u_chk (
  .clk(clk),
  .reset(reset),
  .file_rdata(file_rdata),
  .file_wdata(file_wdata),
  .file_we(file_we),
  .dir_addr(dir_addr),
  .dir_wr(dir_wr),
  .dir_wdata(dir_wdata),
  .dir_rdata(dir_rdata),
  .acc(acc),
  .dir_regs(dir_regs),
  .status_we(status_we),
  .busy(busy),
  .done(done)
);
`default_nettype wire

// ### dv/nibble_swap_and_dir_load_ops_tb_top.sv
// self-checking bench for the exchange and direction load executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module nibble_swap_and_dir_load_ops_tb_top import nsd_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, dir_wr = 1'b0, file_we, status_we, busy, done;
  logic [13:0] instr = '0;
  logic [7:0] file_rdata = '0, dir_wdata = '0, dir_rdata, file_wdata, acc, acc_m = 8'h00;
  logic [6:0] dir_addr = '0, file_addr;
  logic [23:0] dir_regs, dir_m = 24'hffffff;
  logic [46:0] exp_q[$];
  logic [46:0] note;
  int n_fail = 0, tests_run = 0;
  always #25 clk = ~clk;
  nsd_exec DUT (
    .clk(clk),
    .reset(reset),
    .instr(instr),
    .instr_valid(instr_valid),
    .file_addr(file_addr),
    .file_rdata(file_rdata),
    .file_wdata(file_wdata),
    .file_we(file_we),
    .dir_addr(dir_addr),
    .dir_wr(dir_wr),
    .dir_wdata(dir_wdata),
    .dir_rdata(dir_rdata),
    .acc(acc),
    .dir_regs(dir_regs),
    .status_we(status_we),
    .busy(busy),
    .done(done)
  );
  task automatic report_and_stop;
    // a note never retired means a done pulse went missing
    if (exp_q.size() != 0) n_fail++;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // model notes the expected state, one instruction per four clocks
  task automatic op(input logic [13:0] w, input logic v);
    logic [7:0] r;
    r = {file_rdata[3:0], file_rdata[7:4]};
    instr = w;
    instr_valid = v;
    if (v && w[13:8] == 6'h0e) begin
      if (!w[7]) acc_m = r;
      exp_q.push_back({acc_m, dir_m, w[7] ? r : 8'h00, w[7] ? w[6:0] : 7'h00});
    end else if (v && w[13:3] == 11'h00c) begin
      if (w[2:0] >= 3'h5) dir_m[8*(w[2:0]-5)+:8] = acc_m;
      exp_q.push_back({acc_m, dir_m, 8'h00, 7'h00});
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic dw(input logic [6:0] a, input logic [7:0] d);
    logic hit;
    hit = a inside {[7'h05:7'h07]};
    instr_valid = 1'b0;
    dir_addr = a;
    dir_wdata = d;
    dir_wr = 1'b1;
    if (hit) dir_m[8*(a-5)+:8] = d;
    @(posedge clk);
    #1;
    dir_wr = 1'b0;
    `CHK(dir_rdata, hit ? d : 8'h00)
    `CHK(dir_regs, dir_m)
    repeat (3) @(posedge clk);
    #1;
  endtask
  // each done pulse retires the oldest note
  // an unknown done is treated as a pulse so it cannot slip through
  always @(negedge clk) begin
    if (done !== 1'b0) begin
      if (exp_q.size() == 0) begin
        `CHK(done, 1'b0)
      end else begin
        note = exp_q.pop_front();
        `CHK({acc, dir_regs, file_we ? file_wdata : 8'h00, file_we ? file_addr : 7'h00}, note)
      end
    end
  end
  initial begin
    void'($urandom(98447));
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    `CHK({acc, dir_regs}, {nsd_acc_rst, {3{nsd_dir_rst}}})
    for (int i = 0; i < 6; i++) begin
      file_rdata = 8'($urandom);
      op({6'h0e, i[0], 7'($urandom)}, 1'b1);
      op({11'h00c, 3'(5 + i % 3)}, 1'b1);
    end
    // direct write in the direction load's write cycle is dropped
    fork
      op({11'h00c, 3'h6}, 1'b1);
      begin
        repeat (3) @(posedge clk);
        #1;
        dir_addr = 7'h05;
        dir_wdata = 8'($urandom);
        dir_wr = 1'b1;
        @(posedge clk);
        #1;
        dir_wr = 1'b0;
      end
    join
    `CHK(dir_rdata, dir_m[7:0])
    // operand below range, a word without instr_valid and an unknown word change nothing; an exchange then loads acc
    op({11'h00c, 3'h4}, 1'b1);
    op({6'h0e, 8'h25}, 1'b0);
    op(14'h3fff, 1'b1);
    op({6'h0e, 1'b0, 7'h10}, 1'b1);
    for (int i = 4; i < 9; i++) dw(7'(i), 8'($urandom));
    report_and_stop();
  end
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
